// ===== bench/rsp_strap_board.sv
`timescale 1ns/1ns
`default_nettype none
// ====
// board strap resistors
module rsp_strap_board (
    input wire logic [10:0] pullup_fit_in,
    output rsp_pkg::rsp_straps_t straps_out
);
    // unfitted lines sit at the internal pull-down
    always_comb begin
        straps_out = pullup_fit_in;
        // no autoinit pull-up without pci pins
        if (!straps_out.pci_pins_select) begin
            straps_out.pci_autoinit_strap = 1'b0;
        end
    end
endmodule // rsp_strap_board
`default_nettype wire

// ===== bench/rsp_strap_mux_properties.sv
`timescale 1ns/1ns
`default_nettype none
// ====
// strap mux checker
module rsp_strap_mux_chk (
    input wire logic core_clk_in,
    input wire logic reset_in,
    input wire rsp_pkg::rsp_straps_t straps_in,
    input wire logic [rsp_pkg::HOST_PINS-1:0] hp_pad_oe_out,
    input wire logic [rsp_pkg::HOST_PINS-1:0] pci_oe_in,
    input wire logic [rsp_pkg::SER_PINS-1:0] ser_pad_oe_out,
    input wire logic [rsp_pkg::SER_PINS-1:0] ser_oe_in,
    input wire logic [rsp_pkg::SER_PINS-1:0] gpio_ser_oe_in,
    input wire logic internal_clock_output_in,
    input wire logic clk_pad_tx_out,
    input wire logic clk_pad_oe_out,
    input wire logic dram_pins_enable_out,
    input wire logic ext_mem_pins_enable_out,
    input wire logic pci_66mhz_out,
    input wire logic host_port_32bit_out,
    input wire logic [2:0] boot_config_out,
    input wire rsp_pkg::rsp_enables_t periph_active_out,
    input wire logic [rsp_pkg::PLL_MULT_W-1:0] sec_pll_mult_out
);
    rsp_pkg::rsp_straps_t sv_reg;
    rsp_pkg::rsp_enables_t act;
    logic ok_reg;
    assign act = periph_active_out;
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            ok_reg <= 1'b0;
        end else if (!ok_reg) begin
            ok_reg <= 1'b1;
            sv_reg <= straps_in;
        end
    end
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (reset_in);
    pci_speed_a: assert property (
        ok_reg |-> pci_66mhz_out == (sv_reg.pci_pins_select & sv_reg.pci_speed_strap)) else $error("pci speed");
    host_width_a: assert property (
        ok_reg |-> host_port_32bit_out == (!sv_reg.pci_pins_select & sv_reg.host_port_width_strap))
        else $error("host width");
    boot_cfg_a: assert property (
        ok_reg |-> boot_config_out == sv_reg.boot_config_inputs) else $error("boot config");
    held_opts_a: assert property (
        ok_reg && $past(ok_reg) |-> $stable(boot_config_out) && $stable(pci_66mhz_out)
        && $stable(host_port_32bit_out)) else $error("options moved");
    ser_route_a: assert property (
        ok_reg |-> ser_pad_oe_out == (sv_reg.serial_port_pin_select ? ser_oe_in & {6{act.serial_port}}
        : gpio_ser_oe_in & {6{act.gpio}})) else $error("serial pads");
    dead_periph_a: assert property (
        ok_reg |-> (act.serial_port <= sv_reg.serial_port_pin_select) && (act.pci <= sv_reg.pci_pins_select)
        && (act.host_port <= !sv_reg.pci_pins_select) && (act.clock_out <= sv_reg.clock_out_pin_select))
        else $error("deselected active");
    clk_pin_a: assert property (
        ok_reg && sv_reg.clock_out_pin_select && act.clock_out |-> clk_pad_oe_out
        && clk_pad_tx_out == internal_clock_output_in) else $error("clock pin");
    pci_pads_a: assert property (
        ok_reg && sv_reg.pci_pins_select |-> hp_pad_oe_out == (pci_oe_in & {32{act.pci}}))
        else $error("pci pads");
    host_hiz_a: assert property (
        ok_reg && !sv_reg.pci_pins_select && !sv_reg.host_port_width_strap |-> hp_pad_oe_out[31:16] == 16'h0000)
        else $error("upper host pins");
    dram_gate_a: assert property (
        dram_pins_enable_out |-> ok_reg && sv_reg.dram_pins_enable) else $error("dram pins");
    ext_gate_a: assert property (
        ext_mem_pins_enable_out |-> ok_reg && sv_reg.ext_mem_pins_enable) else $error("ext mem pins");
    sec_pll_fixed_a: assert property (
        ok_reg |-> sec_pll_mult_out == rsp_pkg::SEC_PLL_MULT_FIXED) else $error("secondary pll mult");
    boot_enables_a: assert property (
        $rose(ok_reg) |-> periph_active_out == {5'h00, sv_reg.pci_pins_select, !sv_reg.pci_pins_select})
        else $error("reset enables");
endmodule // rsp_strap_mux_chk
bind rsp_strap_mux rsp_strap_mux_chk chk_u (.*);
`default_nettype wire

// ===== bench/rsp_strap_mux_tb.sv
`timescale 1ns/1ns
`default_nettype none
module rsp_strap_mux_tb;
    // ====
    // signals
    logic core_clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic [10:0] fit = 11'h000;
    rsp_pkg::rsp_straps_t straps_in;
    logic [7:0] reg_addr_in = 8'h00;
    logic [31:0] reg_wdata_in = 32'h0;
    logic reg_write_in = 1'b0;
    logic reg_read_in = 1'b0;
    logic [31:0] reg_rdata_out, host_tx_in, host_oe_in, host_rx_out, pci_tx_in, pci_oe_in, pci_rx_out;
    logic [31:0] hp_pad_rx_in, hp_pad_tx_out, hp_pad_oe_out, rd_v;
    logic [5:0] ser_tx_in, ser_oe_in, ser_rx_out, gpio_ser_tx_in, gpio_ser_oe_in, gpio_ser_rx_out;
    logic [5:0] ser_pad_rx_in, ser_pad_tx_out, ser_pad_oe_out;
    logic internal_clock_output_in, gpio_bit_one_tx_in, gpio_bit_one_oe_in, gpio_bit_one_rx_out;
    logic clk_pad_rx_in, clk_pad_tx_out, clk_pad_oe_out, dram_pins_enable_out, ext_mem_pins_enable_out;
    logic pci_66mhz_out, pci_eeprom_autoinit_out, host_port_32bit_out;
    logic [2:0] boot_config_out;
    rsp_pkg::rsp_enables_t periph_active_out;
    logic [4:0] pri_pll_mult_out, sec_pll_mult_out;
    logic [10:0] cfgs [5] = '{11'h000, 11'h7fd, 11'h0c2, 11'h53b, 11'h3c4};
    int miscompares = 0;
    int compares = 0;
    always #50 core_clk_in = ~core_clk_in;
    rsp_strap_board board_u (.pullup_fit_in(fit), .straps_out(straps_in));
    rsp_strap_mux dut_u (.*);
    // ====
    // shared tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_write_in <= 1'b1;
        @(posedge core_clk_in);
        reg_write_in <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge core_clk_in);
        reg_addr_in <= a;
        reg_read_in <= 1'b1;
        @(posedge core_clk_in);
        reg_read_in <= 1'b0;
        #1;
        rd_v = reg_rdata_out;
    endtask
    task automatic boot(input logic [10:0] cfg);
        @(posedge core_clk_in);
        fit <= cfg;
        reset_in <= 1'b1;
        repeat (10) @(posedge core_clk_in);
        reset_in <= 1'b0;
        @(posedge core_clk_in);
        #1;
    endtask
    // ====
    // scenarios
    task automatic t_status(input logic [10:0] cfg);
        logic pci;
        pci = cfg[3];
        boot(cfg);
        rd(rsp_pkg::STATUS_OFS);
        chk(rd_v, {20'h0, 1'b1, cfg});
        rd(rsp_pkg::ACTIVE_OFS);
        chk(rd_v, {30'h0, pci, !pci});
        chk(dram_pins_enable_out, 1'b0);
        chk(boot_config_out, cfg[2:0]);
        chk(pci_66mhz_out, pci & cfg[4]);
        chk(pci_eeprom_autoinit_out, pci & cfg[5]);
        chk(host_port_32bit_out, !pci & cfg[6]);
        $display("status test done cfg=%h", cfg);
    endtask
    task automatic t_hold(input logic [10:0] cfg);
        @(posedge core_clk_in);
        fit <= ~cfg;
        repeat (2) @(posedge core_clk_in);
        rd(rsp_pkg::STATUS_OFS);
        chk(rd_v, {20'h0, 1'b1, cfg});
        chk(boot_config_out, cfg[2:0]);
        $display("hold test done cfg=%h", cfg);
    endtask
    task automatic t_pads(input logic [10:0] cfg);
        logic pci;
        pci = cfg[3];
        wr(rsp_pkg::ENABLE_OFS, 32'h7f);
        host_oe_in <= {cfg, 21'h1f_f0f0};
        pci_oe_in <= {21'h0a_5a5a, cfg};
        hp_pad_rx_in <= {cfg, cfg, cfg[9:0]};
        ser_oe_in <= cfg[5:0];
        gpio_ser_oe_in <= ~cfg[5:0];
        ser_pad_rx_in <= ~cfg[10:5];
        internal_clock_output_in <= cfg[0];
        gpio_bit_one_tx_in <= ~cfg[0];
        gpio_bit_one_oe_in <= cfg[1];
        @(posedge core_clk_in);
        #1;
        chk(hp_pad_oe_out, pci ? pci_oe_in : {cfg[6] ? host_oe_in[31:16] : 16'h0, host_oe_in[15:0]});
        chk(pci_rx_out, pci ? hp_pad_rx_in : 32'h0);
        chk(host_rx_out[15:0], pci ? 16'h0 : hp_pad_rx_in[15:0]);
        chk(ser_pad_oe_out, cfg[7] ? ser_oe_in : gpio_ser_oe_in);
        chk(ser_rx_out, cfg[7] ? ser_pad_rx_in : 6'h0);
        chk(clk_pad_tx_out, cfg[8] ? internal_clock_output_in : gpio_bit_one_tx_in);
        chk(clk_pad_oe_out, cfg[8] ? 1'b1 : cfg[1]);
        chk(hp_pad_tx_out, pci ? pci_tx_in : host_tx_in);
        chk(ser_pad_tx_out, cfg[7] ? ser_tx_in : gpio_ser_tx_in);
        chk(gpio_ser_rx_out, cfg[7] ? 6'h0 : ser_pad_rx_in);
        chk(gpio_bit_one_rx_out, cfg[8] ? 1'b0 : clk_pad_rx_in);
        chk(dram_pins_enable_out, cfg[9]);
        chk(ext_mem_pins_enable_out, cfg[10]);
        rd(rsp_pkg::ACTIVE_OFS);
        chk(rd_v & 32'h77, {cfg[8], cfg[10], cfg[9], 1'b0, cfg[7], pci, !pci});
        $display("pad test done cfg=%h", cfg);
    endtask
    task automatic t_pll;
        rd(rsp_pkg::PLL_OFS);
        chk(rd_v, {19'h0, rsp_pkg::SEC_PLL_MULT_FIXED, 3'h0, rsp_pkg::PRI_PLL_MULT_RESET});
        wr(rsp_pkg::PLL_OFS, 32'hffff_ffff);
        rd(rsp_pkg::PLL_OFS);
        chk(rd_v, {19'h0, rsp_pkg::SEC_PLL_MULT_FIXED, 8'h1f});
        chk(pri_pll_mult_out, 5'h1f);
        wr(8'h10, 32'hffff_ffff);
        rd(8'h10);
        chk(rd_v, 32'h0);
        chk(sec_pll_mult_out, rsp_pkg::SEC_PLL_MULT_FIXED);
        $display("pll test done");
    endtask
    task automatic test_done;
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // ====
    // main sequence
    initial begin
        host_tx_in = 32'h1234_5678;
        pci_tx_in = 32'h8765_4321;
        ser_tx_in = 6'h15;
        gpio_ser_tx_in = 6'h2a;
        gpio_bit_one_oe_in = 1'b1;
        host_oe_in = 32'h0;
        pci_oe_in = 32'h0;
        hp_pad_rx_in = 32'h0;
        ser_oe_in = 6'h0;
        gpio_ser_oe_in = 6'h0;
        ser_pad_rx_in = 6'h0;
        internal_clock_output_in = 1'b0;
        gpio_bit_one_tx_in = 1'b0;
        clk_pad_rx_in = 1'b1;
        foreach (cfgs[i]) begin
            t_status(cfgs[i]);
            t_hold(cfgs[i]);
            t_pads(cfgs[i]);
        end
        t_pll;
        test_done;
    end
    initial begin
        #1_000_000;
        miscompares++;
        test_done;
    end
endmodule // rsp_strap_mux_tb
`default_nettype wire

// ===== design/rsp_pin_select.sv
`timescale 1ns/1ns
`default_nettype none

module rsp_pin_select #(
    parameter int W = 1
) (
    input wire logic a_sel_in,
    input wire logic b_sel_in,
    input wire logic [W-1:0] a_tx_in,
    input wire logic [W-1:0] a_oe_in,
    input wire logic [W-1:0] b_tx_in,
    input wire logic [W-1:0] b_oe_in,
    input wire logic [W-1:0] pad_rx_in,
    output logic [W-1:0] pad_tx_out,
    output logic [W-1:0] pad_oe_out,
    output logic [W-1:0] a_rx_out,
    output logic [W-1:0] b_rx_out
);

    // ==========================================================
    // one function per pin, a wins only if b is off
    always_comb begin
        pad_tx_out = '0;
        pad_oe_out = '0;
        if (a_sel_in && !b_sel_in) begin
            pad_tx_out = a_tx_in;
            pad_oe_out = a_oe_in;
        end else if (b_sel_in && !a_sel_in) begin
            pad_tx_out = b_tx_in;
            pad_oe_out = b_oe_in;
        end
        a_rx_out = a_sel_in ? pad_rx_in : '0;
        b_rx_out = b_sel_in ? pad_rx_in : '0;
    end

endmodule // rsp_pin_select

`default_nettype wire

// ===== design/rsp_pkg.sv
package rsp_pkg;

    // ==========================================================
    // widths
    localparam int HOST_PINS = 32;
    localparam int HOST_LOW_PINS = 16;
    localparam int SER_PINS = 6;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int PLL_MULT_W = 5;

    // ==========================================================
    // register offsets
    localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h00;
    localparam logic [ADDR_W-1:0] ENABLE_OFS = 8'h04;
    localparam logic [ADDR_W-1:0] ACTIVE_OFS = 8'h08;
    localparam logic [ADDR_W-1:0] PLL_OFS = 8'h0c;

    // ==========================================================
    // field positions
    localparam int STATUS_CAPTURED_BIT = 11;
    localparam int PRI_PLL_MULT_LSB = 0;
    localparam int SEC_PLL_MULT_LSB = 8;

    // ==========================================================
    // reset values
    localparam logic [6:0] ENABLE_RESET = 7'h03;
    localparam logic [PLL_MULT_W-1:0] PRI_PLL_MULT_RESET = 5'h01;
    localparam logic [PLL_MULT_W-1:0] SEC_PLL_MULT_FIXED = 5'h0a;

    // ==========================================================
    // carriers
    typedef struct packed {
        logic ext_mem_pins_enable;
        logic dram_pins_enable;
        logic clock_out_pin_select;
        logic serial_port_pin_select;
        logic host_port_width_strap;
        logic pci_autoinit_strap;
        logic pci_speed_strap;
        logic pci_pins_select;
        logic [2:0] boot_config_inputs;
    } rsp_straps_t;

    typedef struct packed {
        logic clock_out;
        logic ext_mem;
        logic dram;
        logic gpio;
        logic serial_port;
        logic pci;
        logic host_port;
    } rsp_enables_t;

    typedef struct packed {
        logic captured;
        rsp_straps_t straps;
    } rsp_capture_state_t;

    typedef struct packed {
        rsp_enables_t sw_en;
        logic [PLL_MULT_W-1:0] pri_pll_mult;
        logic [DATA_W-1:0] rdata;
    } rsp_mux_state_t;

endpackage

// ===== design/rsp_strap_capture.sv
`timescale 1ns/1ns
`default_nettype none

module rsp_strap_capture (
    input wire logic core_clk_in,
    input wire logic reset_in,
    input wire rsp_pkg::rsp_straps_t straps_in,
    output rsp_pkg::rsp_straps_t straps_out,
    output logic captured_out
);

    // ==========================================================
    // state
    rsp_pkg::rsp_capture_state_t state_reg;
    rsp_pkg::rsp_capture_state_t state_next;

    always_comb begin
        state_next = state_reg;
        if (!state_reg.captured) begin
            state_next.captured = 1'b1;
            state_next.straps = straps_in;
        end
    end

    // held until the next reset
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign straps_out = state_reg.straps;
    assign captured_out = state_reg.captured;

endmodule // rsp_strap_capture

`default_nettype wire

// ===== design/rsp_strap_mux.sv
// Contract
// - pci selected with speed strap high: pci runs at 66 MHz.
// - serial select strap 1 routes shared pins to serial port, 0 to gpio.
// - clock select strap 1 drives internal clock on pin, 0 leaves gpio bit one.
// - boot config inputs captured into a status register after reset.
// - host/pci strap 1 gives shared pins to pci, 0 to host port.
// - dram pins enabled only when their strap latched 1.
// - external memory pins enabled only when their strap latched 1.
// - never two peripheral functions on one shared pin.
// - deselected peripheral stays disabled until selected and reset again, except gpio, which follows its software bit with no pins selected.
// - selecting pin function does not enable the peripheral.
// - peripherals leave reset disabled except boot ones; software enables rest.
// - strap options hold until another reset latches new values.
// - primary pll multiplier set by software; secondary multiplier fixed.
// - host width strap 0: 16-bit, upper pins hi-z; 1: 32-bit.
// - pci selected with speed strap 0: pci runs at 33 MHz.
// - autoinit strap 1 loads pci config from eeprom, 0 uses defaults.
`timescale 1ns/1ns
`default_nettype none

module rsp_strap_mux (
    input wire logic core_clk_in,
    input wire logic reset_in,
    input wire rsp_pkg::rsp_straps_t straps_in,
    input wire logic [rsp_pkg::ADDR_W-1:0] reg_addr_in,
    input wire logic [rsp_pkg::DATA_W-1:0] reg_wdata_in,
    input wire logic reg_write_in,
    input wire logic reg_read_in,
    output logic [rsp_pkg::DATA_W-1:0] reg_rdata_out,
    input wire logic [rsp_pkg::HOST_PINS-1:0] host_tx_in,
    input wire logic [rsp_pkg::HOST_PINS-1:0] host_oe_in,
    output logic [rsp_pkg::HOST_PINS-1:0] host_rx_out,
    input wire logic [rsp_pkg::HOST_PINS-1:0] pci_tx_in,
    input wire logic [rsp_pkg::HOST_PINS-1:0] pci_oe_in,
    output logic [rsp_pkg::HOST_PINS-1:0] pci_rx_out,
    input wire logic [rsp_pkg::HOST_PINS-1:0] hp_pad_rx_in,
    output logic [rsp_pkg::HOST_PINS-1:0] hp_pad_tx_out,
    output logic [rsp_pkg::HOST_PINS-1:0] hp_pad_oe_out,
    input wire logic [rsp_pkg::SER_PINS-1:0] ser_tx_in,
    input wire logic [rsp_pkg::SER_PINS-1:0] ser_oe_in,
    output logic [rsp_pkg::SER_PINS-1:0] ser_rx_out,
    input wire logic [rsp_pkg::SER_PINS-1:0] gpio_ser_tx_in,
    input wire logic [rsp_pkg::SER_PINS-1:0] gpio_ser_oe_in,
    output logic [rsp_pkg::SER_PINS-1:0] gpio_ser_rx_out,
    input wire logic [rsp_pkg::SER_PINS-1:0] ser_pad_rx_in,
    output logic [rsp_pkg::SER_PINS-1:0] ser_pad_tx_out,
    output logic [rsp_pkg::SER_PINS-1:0] ser_pad_oe_out,
    input wire logic internal_clock_output_in,
    input wire logic gpio_bit_one_tx_in,
    input wire logic gpio_bit_one_oe_in,
    output logic gpio_bit_one_rx_out,
    input wire logic clk_pad_rx_in,
    output logic clk_pad_tx_out,
    output logic clk_pad_oe_out,
    output logic dram_pins_enable_out,
    output logic ext_mem_pins_enable_out,
    output logic pci_66mhz_out,
    output logic pci_eeprom_autoinit_out,
    output logic host_port_32bit_out,
    output logic [2:0] boot_config_out,
    output rsp_pkg::rsp_enables_t periph_active_out,
    output logic [rsp_pkg::PLL_MULT_W-1:0] pri_pll_mult_out,
    output logic [rsp_pkg::PLL_MULT_W-1:0] sec_pll_mult_out
);

    // ==========================================================
    // address decode
    function automatic logic reg_hit(input logic [rsp_pkg::ADDR_W-1:0] addr,
                                     input logic [rsp_pkg::ADDR_W-1:0] ofs);
        reg_hit = (addr == ofs);
    endfunction

    // ==========================================================
    // strap capture
    rsp_pkg::rsp_straps_t straps;
    logic captured;

    rsp_strap_capture u_capture (
        .core_clk_in(core_clk_in),
        .reset_in(reset_in),
        .straps_in(straps_in),
        .straps_out(straps),
        .captured_out(captured)
    );

    // ==========================================================
    // pin function selection from held copies only
    logic host_sel;
    logic pci_sel;
    logic ser_sel;
    logic gpio_ser_sel;
    logic clk_sel;
    logic gpio_one_sel;

    assign host_sel = captured && !straps.pci_pins_select;
    assign pci_sel = captured && straps.pci_pins_select;
    assign ser_sel = captured && straps.serial_port_pin_select;
    assign gpio_ser_sel = captured && !straps.serial_port_pin_select;
    assign clk_sel = captured && straps.clock_out_pin_select;
    assign gpio_one_sel = captured && !straps.clock_out_pin_select;

    // ==========================================================
    // state
    rsp_pkg::rsp_mux_state_t state_reg;
    rsp_pkg::rsp_mux_state_t state_next;
    rsp_pkg::rsp_enables_t active;
    logic [rsp_pkg::DATA_W-1:0] status_word;
    logic [rsp_pkg::DATA_W-1:0] pll_word;

    // ==========================================================
    // effective enables: software bit gated by pin function, except gpio which is gated only by capture
    always_comb begin
        active.host_port = host_sel && state_reg.sw_en.host_port;
        active.pci = pci_sel && state_reg.sw_en.pci;
        active.serial_port = ser_sel && state_reg.sw_en.serial_port;
        active.gpio = captured && state_reg.sw_en.gpio;
        active.dram = captured && straps.dram_pins_enable && state_reg.sw_en.dram;
        active.ext_mem = captured && straps.ext_mem_pins_enable && state_reg.sw_en.ext_mem;
        active.clock_out = clk_sel && state_reg.sw_en.clock_out;
    end

    always_comb begin
        status_word = '0;
        status_word[$bits(rsp_pkg::rsp_straps_t)-1:0] = straps;
        status_word[rsp_pkg::STATUS_CAPTURED_BIT] = captured;
        pll_word = '0;
        pll_word[rsp_pkg::PRI_PLL_MULT_LSB +: rsp_pkg::PLL_MULT_W] = state_reg.pri_pll_mult;
        pll_word[rsp_pkg::SEC_PLL_MULT_LSB +: rsp_pkg::PLL_MULT_W] = rsp_pkg::SEC_PLL_MULT_FIXED;
    end

    // ==========================================================
    // register access
    always_comb begin
        state_next = state_reg;
        state_next.rdata = '0;
        if (reg_write_in) begin
            if (reg_hit(reg_addr_in, rsp_pkg::ENABLE_OFS)) begin
                state_next.sw_en = reg_wdata_in[$bits(rsp_pkg::rsp_enables_t)-1:0];
            end
            if (reg_hit(reg_addr_in, rsp_pkg::PLL_OFS)) begin
                state_next.pri_pll_mult = reg_wdata_in[rsp_pkg::PRI_PLL_MULT_LSB +: rsp_pkg::PLL_MULT_W];
            end
        end
        if (reg_read_in) begin
            if (reg_hit(reg_addr_in, rsp_pkg::STATUS_OFS)) begin
                state_next.rdata = status_word;
            end else if (reg_hit(reg_addr_in, rsp_pkg::ENABLE_OFS)) begin
                state_next.rdata = {{(rsp_pkg::DATA_W-$bits(rsp_pkg::rsp_enables_t)){1'b0}}, state_reg.sw_en};
            end else if (reg_hit(reg_addr_in, rsp_pkg::ACTIVE_OFS)) begin
                state_next.rdata = {{(rsp_pkg::DATA_W-$bits(rsp_pkg::rsp_enables_t)){1'b0}}, active};
            end else if (reg_hit(reg_addr_in, rsp_pkg::PLL_OFS)) begin
                state_next.rdata = pll_word;
            end
        end
    end

    // only boot ports come out of reset enabled
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            state_reg.sw_en <= rsp_pkg::ENABLE_RESET;
            state_reg.pri_pll_mult <= rsp_pkg::PRI_PLL_MULT_RESET;
            state_reg.rdata <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign reg_rdata_out = state_reg.rdata;

    // ==========================================================
    // host port / pci shared pins
    logic [rsp_pkg::HOST_PINS-1:0] host_oe_gated;
    logic [rsp_pkg::HOST_PINS-1:0] pci_oe_gated;

    always_comb begin
        host_oe_gated = active.host_port ? host_oe_in : '0;
        if (!straps.host_port_width_strap) begin
            host_oe_gated[rsp_pkg::HOST_PINS-1:rsp_pkg::HOST_LOW_PINS] = '0;
        end
        pci_oe_gated = active.pci ? pci_oe_in : '0;
    end

    rsp_pin_select #(
        .W(rsp_pkg::HOST_PINS)
    ) u_hp_pins (
        .a_sel_in(host_sel),
        .b_sel_in(pci_sel),
        .a_tx_in(host_tx_in),
        .a_oe_in(host_oe_gated),
        .b_tx_in(pci_tx_in),
        .b_oe_in(pci_oe_gated),
        .pad_rx_in(hp_pad_rx_in),
        .pad_tx_out(hp_pad_tx_out),
        .pad_oe_out(hp_pad_oe_out),
        .a_rx_out(host_rx_out),
        .b_rx_out(pci_rx_out)
    );

    // ==========================================================
    // serial port / gpio shared pins
    rsp_pin_select #(
        .W(rsp_pkg::SER_PINS)
    ) u_ser_pins (
        .a_sel_in(ser_sel),
        .b_sel_in(gpio_ser_sel),
        .a_tx_in(ser_tx_in),
        .a_oe_in(active.serial_port ? ser_oe_in : '0),
        .b_tx_in(gpio_ser_tx_in),
        .b_oe_in(active.gpio ? gpio_ser_oe_in : '0),
        .pad_rx_in(ser_pad_rx_in),
        .pad_tx_out(ser_pad_tx_out),
        .pad_oe_out(ser_pad_oe_out),
        .a_rx_out(ser_rx_out),
        .b_rx_out(gpio_ser_rx_out)
    );

    // ==========================================================
    // clock output / gpio bit one pin
    rsp_pin_select #(
        .W(1)
    ) u_clk_pin (
        .a_sel_in(clk_sel),
        .b_sel_in(gpio_one_sel),
        .a_tx_in(internal_clock_output_in),
        .a_oe_in(active.clock_out),
        .b_tx_in(gpio_bit_one_tx_in),
        .b_oe_in(active.gpio && gpio_bit_one_oe_in),
        .pad_rx_in(clk_pad_rx_in),
        .pad_tx_out(clk_pad_tx_out),
        .pad_oe_out(clk_pad_oe_out),
        .a_rx_out(),
        .b_rx_out(gpio_bit_one_rx_out)
    );

    // ==========================================================
    // option outputs
    assign dram_pins_enable_out = active.dram;
    assign ext_mem_pins_enable_out = active.ext_mem;
    assign pci_66mhz_out = pci_sel && straps.pci_speed_strap;
    assign pci_eeprom_autoinit_out = pci_sel && straps.pci_autoinit_strap;
    assign host_port_32bit_out = host_sel && straps.host_port_width_strap;
    assign boot_config_out = straps.boot_config_inputs;
    assign periph_active_out = active;
    assign pri_pll_mult_out = state_reg.pri_pll_mult;
    assign sec_pll_mult_out = rsp_pkg::SEC_PLL_MULT_FIXED;

endmodule // rsp_strap_mux

`default_nettype wire
